// ===== tc_irq_pkg.sv
// Constants shared by the timer channel interrupt and status block.
// Assumes a 32-bit byte-addressed register port with word-aligned registers; offsets are byte addresses.
package tc_irq_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_IRQ_SET = 8'h04;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

	// Event bit positions, common to status, enable, disable and mask
	localparam int EV_OVERFLOW = 0;
	localparam int EV_LOAD_OVERRUN = 1;
	localparam int EV_COMPARE_A = 2;
	localparam int EV_COMPARE_B = 3;
	localparam int EV_COMPARE_C = 4;
	localparam int EV_LOAD_A = 5;
	localparam int EV_LOAD_B = 6;
	localparam int EV_EXT_TRIGGER = 7;
	localparam int EV_COUNT = 8;

	// Live status bit positions
	localparam int POS_CLOCK_ON = 16;
	localparam int POS_LINE_A = 17;
	localparam int POS_LINE_B = 18;

	// Sources that may raise a flag in each mode
	localparam logic [7:0] SRC_CAPTURE = 8'hF3;
	localparam logic [7:0] SRC_WAVE = 8'h9D;

	// Reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h00000000;

	// Read data of an unmapped or write-only address
	localparam logic [31:0] RDATA_NONE = 32'h00000000;

	typedef struct packed {
		logic syncA1;
		logic syncA2;
		logic syncB1;
		logic syncB2;
		logic clockOnSt;
		logic mirrorA;
		logic mirrorB;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [31:0] rdata;
		logic irq;
	} chan_state_t;

endpackage

// ===== timer_channel_irq_mask_status.sv
// Interrupt enable, disable, mask and status logic of one timer channel.
// Assumes event pulses, mode, clock-on and driven line levels come from the
// channel datapath on the same clock; the two line pins are asynchronous.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

module timer_channel_irq_mask_status (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	// Channel datapath
	input wire logic [7:0] eventPulse,
	input wire logic waveMode,
	input wire logic clockOn,
	input wire logic drivenLineA,
	input wire logic drivenLineB,
	// Timer line pins, asynchronous
	input wire logic timerLineA,
	input wire logic timerLineB,
	// Interrupt
	output logic irqOut
);
	import tc_irq_pkg::*;

	chan_state_t st_r;
	chan_state_t st_nxt;
	logic [7:0] gatedEv;
	logic [7:0] srcAllowed;
	logic rdStatus;
	logic rdMask;
	logic wrSet;
	logic wrClr;

	assign rdStatus = regRead && (regAddr == OFF_STATUS);
	assign rdMask = regRead && (regAddr == OFF_IRQ_MASK);
	assign wrSet = regWrite && (regAddr == OFF_IRQ_SET);
	assign wrClr = regWrite && (regAddr == OFF_IRQ_CLR);

	// Sources that are meaningless in the current mode never raise a flag
	assign srcAllowed = waveMode ? SRC_WAVE : SRC_CAPTURE;

	genvar gi;
	generate
		for (gi = 0; gi < EV_COUNT; gi++) begin : g_event
			assign gatedEv[gi] = eventPulse[gi] && srcAllowed[gi];
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		// Pin synchronisers; first stage feeds only the second
		st_nxt.syncA1 = timerLineA;
		st_nxt.syncA2 = st_r.syncA1;
		st_nxt.syncB1 = timerLineB;
		st_nxt.syncB2 = st_r.syncB1;
		st_nxt.clockOnSt = clockOn;
		// In waveform mode the pin may lag the driver, so show the driver
		st_nxt.mirrorA = waveMode ? drivenLineA : st_r.syncA2;
		st_nxt.mirrorB = waveMode ? drivenLineB : st_r.syncB2;
		// A status read clears the flags, but an event in the same cycle survives
		if (rdStatus) begin
			st_nxt.flags = RST_FLAGS;
		end
		st_nxt.flags = st_nxt.flags | gatedEv;
		// Mask changes only through the set and clear ports
		if (wrSet) begin
			st_nxt.mask = st_r.mask | regWdata[7:0];
		end else if (wrClr) begin
			st_nxt.mask = st_r.mask & ~regWdata[7:0];
		end
		// Read data stand only in the cycle after the strobe
		st_nxt.rdata = RDATA_NONE;
		if (regRead) begin
			case (regAddr)
				OFF_STATUS: begin
					st_nxt.rdata[7:0] = st_r.flags;
					st_nxt.rdata[POS_CLOCK_ON] = st_r.clockOnSt;
					st_nxt.rdata[POS_LINE_A] = st_r.mirrorA;
					st_nxt.rdata[POS_LINE_B] = st_r.mirrorB;
				end
				OFF_IRQ_MASK: begin
					st_nxt.rdata[7:0] = st_r.mask;
				end
				// Set and clear ports are write-only and read as zero
				default: begin
					st_nxt.rdata = RDATA_NONE;
				end
			endcase
		end
		// Driven from next values so the output is not a cycle late
		st_nxt.irq = |(st_nxt.flags & st_nxt.mask);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{syncA1: 1'b0, syncA2: 1'b0, syncB1: 1'b0, syncB2: 1'b0,
				clockOnSt: 1'b0, mirrorA: 1'b0, mirrorB: 1'b0,
				flags: RST_FLAGS, mask: RST_MASK, rdata: RST_RDATA,
				irq: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdata = st_r.rdata;
	assign irqOut = st_r.irq;

	// Checks

	sequence s_readStatus;
		regRead && (regAddr == OFF_STATUS);
	endsequence

	sequence s_readMask;
		rdMask;
	endsequence

	sequence s_writeSet;
		regWrite && (regAddr == OFF_IRQ_SET);
	endsequence

	sequence s_writeClr;
		regWrite && (regAddr == OFF_IRQ_CLR);
	endsequence

	property p_clockOnBit;
		@(posedge clock) disable iff (!nrst)
		s_readStatus |=> regRdata[POS_CLOCK_ON] == $past(clockOn, 2);
	endproperty
	a_clockOnBit: assert property (p_clockOnBit)
		else $error("clock-on status bit wrong");

	property p_lineACapture;
		@(posedge clock) disable iff (!nrst)
		(s_readStatus and ($past(!waveMode) && $past(nrst, 3)))
			|=> regRdata[POS_LINE_A] == $past(timerLineA, 4);
	endproperty
	a_lineACapture: assert property (p_lineACapture)
		else $error("line A mirror does not follow pin");

	property p_lineAWave;
		@(posedge clock) disable iff (!nrst)
		(s_readStatus and $past(waveMode))
			|=> regRdata[POS_LINE_A] == $past(drivenLineA, 2);
	endproperty
	a_lineAWave: assert property (p_lineAWave)
		else $error("line A mirror does not follow driver");

	property p_lineB;
		@(posedge clock) disable iff (!nrst)
		(s_readStatus and $past(nrst, 3))
			|=> regRdata[POS_LINE_B] == ($past(waveMode, 2) ?
				$past(drivenLineB, 2) : $past(timerLineB, 4));
	endproperty
	a_lineB: assert property (p_lineB)
		else $error("line B mirror wrong");

	property p_maskSet;
		@(posedge clock) disable iff (!nrst)
		s_writeSet |=>
			st_r.mask == ($past(st_r.mask) | $past(regWdata[7:0]));
	endproperty
	a_maskSet: assert property (p_maskSet)
		else $error("enable write did not set mask bits");

	property p_maskClr;
		@(posedge clock) disable iff (!nrst)
		s_writeClr |=> st_r.mask == ($past(st_r.mask) & ~$past(regWdata[7:0]));
	endproperty
	a_maskClr: assert property (p_maskClr)
		else $error("disable write did not clear mask bits");

	property p_maskRead;
		@(posedge clock) disable iff (!nrst)
		s_readMask |=> regRdata == {24'h000000, $past(st_r.mask)};
	endproperty
	a_maskRead: assert property (p_maskRead)
		else $error("mask read wrong");

	property p_modeGate;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (st_r.flags & ~$past(st_r.flags) &
			~($past(waveMode) ? SRC_WAVE : SRC_CAPTURE)) == 8'h00;
	endproperty
	a_modeGate: assert property (p_modeGate)
		else $error("flag raised by a source not valid in this mode");

	property p_maskStable;
		@(posedge clock) disable iff (!nrst)
		!(regWrite && (regAddr == OFF_IRQ_SET || regAddr == OFF_IRQ_CLR))
			|=> $stable(st_r.mask);
	endproperty
	a_maskStable: assert property (p_maskStable)
		else $error("mask changed without an enable or disable write");

	property p_writeOnlyRead;
		@(posedge clock) disable iff (!nrst)
		regRead && (regAddr == OFF_IRQ_SET || regAddr == OFF_IRQ_CLR)
			|=> regRdata == 32'h00000000;
	endproperty
	a_writeOnlyRead: assert property (p_writeOnlyRead)
		else $error("write-only register returned data");

	property p_readClears;
		@(posedge clock) disable iff (!nrst)
		s_readStatus |=> st_r.flags == $past(gatedEv)
			&& regRdata[7:0] == $past(st_r.flags);
	endproperty
	a_readClears: assert property (p_readClears)
		else $error("status read did not clear flags");

	property p_eventKept;
		@(posedge clock) disable iff (!nrst)
		(gatedEv != 8'h00) |=> (st_r.flags & $past(gatedEv)) == $past(gatedEv);
	endproperty
	a_eventKept: assert property (p_eventKept)
		else $error("event lost");

	property p_statusLayout;
		@(posedge clock) disable iff (!nrst)
		s_readStatus |=> regRdata[15:8] == 8'h00 && regRdata[31:19] == 13'h0;
	endproperty
	a_statusLayout: assert property (p_statusLayout)
		else $error("status reserved bits not zero");

	property p_irqLevel;
		@(posedge clock) disable iff (!nrst)
		irqOut == |(st_r.flags & st_r.mask);
	endproperty
	a_irqLevel: assert property (p_irqLevel)
		else $error("interrupt level disagrees with flags and mask");

	property p_irqAfterEnable;
		@(posedge clock) disable iff (!nrst)
		(s_writeSet and ((regWdata[7:0] & st_r.flags) != 8'h00)
			and !rdStatus) |=> irqOut;
	endproperty
	a_irqAfterEnable: assert property (p_irqAfterEnable)
		else $error("interrupt not raised after enabling a set flag");

	// Read data stand for one cycle only, then fall back to zero
	property p_rdataIdle;
		@(posedge clock) disable iff (!nrst)
		!regRead |=> regRdata == 32'h00000000;
	endproperty
	a_rdataIdle: assert property (p_rdataIdle)
		else $error("read data did not return to zero");

	property p_unmappedRead;
		@(posedge clock) disable iff (!nrst)
		regRead && regAddr != OFF_STATUS && regAddr != OFF_IRQ_MASK
			|=> regRdata == 32'h00000000;
	endproperty
	a_unmappedRead: assert property (p_unmappedRead)
		else $error("unreadable address returned data");

	property p_maskWrongWrite;
		@(posedge clock) disable iff (!nrst)
		regWrite && (regAddr == OFF_STATUS || regAddr == OFF_IRQ_MASK)
			|=> $stable(st_r.mask);
	endproperty
	a_maskWrongWrite: assert property (p_maskWrongWrite)
		else $error("mask changed by a write to a read-only address");

	property p_setKeeps;
		@(posedge clock) disable iff (!nrst)
		s_writeSet |=> (st_r.mask & $past(st_r.mask)) == $past(st_r.mask);
	endproperty
	a_setKeeps: assert property (p_setKeeps)
		else $error("enable write cleared a mask bit");

	property p_clrKeeps;
		@(posedge clock) disable iff (!nrst)
		s_writeClr |=> (st_r.mask & ~$past(st_r.mask)) == 8'h00;
	endproperty
	a_clrKeeps: assert property (p_clrKeeps)
		else $error("disable write set a mask bit");

	property p_flagsHold;
		@(posedge clock) disable iff (!nrst)
		!rdStatus |=> st_r.flags == ($past(st_r.flags) | $past(gatedEv));
	endproperty
	a_flagsHold: assert property (p_flagsHold)
		else $error("flags changed without a status read");

	property p_waveBlocksLoad;
		@(posedge clock) disable iff (!nrst)
		waveMode && !st_r.flags[EV_LOAD_A] && !st_r.flags[EV_LOAD_B]
			|=> !st_r.flags[EV_LOAD_A] && !st_r.flags[EV_LOAD_B];
	endproperty
	a_waveBlocksLoad: assert property (p_waveBlocksLoad)
		else $error("load flag raised in waveform mode");

	property p_captureBlocksCompare;
		@(posedge clock) disable iff (!nrst)
		!waveMode && !st_r.flags[EV_COMPARE_A] && !st_r.flags[EV_COMPARE_B]
			|=> !st_r.flags[EV_COMPARE_A] && !st_r.flags[EV_COMPARE_B];
	endproperty
	a_captureBlocksCompare: assert property (p_captureBlocksCompare)
		else $error("compare flag raised in capture mode");

	property p_irqAfterEvent;
		@(posedge clock) disable iff (!nrst)
		(gatedEv & st_r.mask) != 8'h00 && !wrClr |=> irqOut;
	endproperty
	a_irqAfterEvent: assert property (p_irqAfterEvent)
		else $error("interrupt not raised by an enabled event");

	property p_irqAfterDisable;
		@(posedge clock) disable iff (!nrst)
		s_writeClr and (regWdata[7:0] == 8'hFF) |=> !irqOut;
	endproperty
	a_irqAfterDisable: assert property (p_irqAfterDisable)
		else $error("interrupt still high after disabling all sources");

endmodule

// ===== datapath_model.sv
// Behavioural channel datapath that feeds the interrupt and status block.
// Assumes the bench raises a request for exactly one clock edge.
`timescale 1ns/1ps
module datapath_model (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Requests from the bench
	input wire logic [7:0] fireReq,
	input wire logic [5:0] cfgReq,
	// Block side: pinB, pinA, drivenB, drivenA, clockOn, waveMode
	output logic [7:0] eventPulse,
	output logic [5:0] lvl
);
	// Registered, so every event is a clean one-cycle pulse
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			eventPulse <= 8'h00;
			lvl <= 6'h00;
		end else begin
			eventPulse <= fireReq;
			lvl <= cfgReq;
		end
	end
endmodule

// ===== timer_channel_irq_mask_status_tb_top.sv
// Self-checking bench for the timer channel interrupt and status block.
// Assumes the datapath model adds one cycle before the block sees a change.
`timescale 1ns/1ps
module timer_channel_irq_mask_status_tb_top;
	import tc_irq_pkg::*;
	logic clock, nrst, regWrite, regRead, irqOut;
	logic [7:0] regAddr, fireReq, eventPulse;
	logic [31:0] regWdata, regRdata, rv;
	logic [5:0] cfgReq, lvl;
	logic [1:0] ln;
	int errors, n_compared;

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	datapath_model model (.clock(clock), .nrst(nrst), .fireReq(fireReq),
		.cfgReq(cfgReq), .eventPulse(eventPulse), .lvl(lvl));

	timer_channel_irq_mask_status dut (.clock(clock), .nrst(nrst),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .eventPulse(eventPulse),
		.waveMode(lvl[0]), .clockOn(lvl[1]), .drivenLineA(lvl[2]),
		.drivenLineB(lvl[3]), .timerLineA(lvl[4]), .timerLineB(lvl[5]),
		.irqOut(irqOut));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		// Let the write land before anyone looks at the outputs
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic fire(input logic [7:0] m);
		@(posedge clock);
		fireReq <= m;
		@(posedge clock);
		fireReq <= 8'h00;
		repeat (3) @(posedge clock);
	endtask

	task automatic summarize;
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		summarize();
	end

	initial begin
		nrst = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h00000000;
		regWrite = 1'b0;
		regRead = 1'b0;
		fireReq = 8'h00;
		cfgReq = 6'h00;
		errors = 0;
		n_compared = 0;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		rd(OFF_IRQ_MASK, rv);
		chk(rv, 32'h00000000);
		rd(OFF_STATUS, rv);
		chk(rv, 32'h00000000);
		wr(OFF_IRQ_SET, 32'h000000FF);
		wr(OFF_IRQ_CLR, 32'h0000000F);
		wr(OFF_IRQ_SET, 32'h00000000);
		wr(OFF_IRQ_CLR, 32'h00000000);
		wr(OFF_IRQ_MASK, 32'h0000000F);
		rd(OFF_IRQ_MASK, rv);
		chk(rv, 32'h000000F0);
		rd(OFF_IRQ_SET, rv);
		chk(rv, 32'h00000000);
		rd(OFF_IRQ_CLR, rv);
		chk(rv, 32'h00000000);
		rd(8'h10, rv);
		chk(rv, 32'h00000000);
		wr(OFF_IRQ_CLR, 32'h000000FF);
		$display("test mask done");
		// One source at a time, in a mode where it may arrive
		for (int i = 0; i < EV_COUNT; i++) begin
			@(posedge clock);
			cfgReq <= {5'h00, i == EV_COMPARE_A || i == EV_COMPARE_B};
			wr(OFF_IRQ_SET, 32'h1 << i);
			chk({31'h0, irqOut}, 32'h0);
			fire(8'h01 << i);
			chk({31'h0, irqOut}, 32'h1);
			rd(OFF_STATUS, rv);
			chk(rv, 32'h1 << i);
			chk({31'h0, irqOut}, 32'h0);
			wr(OFF_IRQ_CLR, 32'h1 << i);
			rd(OFF_IRQ_MASK, rv);
			chk(rv, 32'h00000000);
		end
		$display("test layout done");
		@(posedge clock);
		cfgReq <= 6'h02;
		fire(8'hFF);
		rd(OFF_STATUS, rv);
		chk(rv, 32'h000100F3);
		rd(OFF_STATUS, rv);
		chk(rv, 32'h00010000);
		@(posedge clock);
		cfgReq <= 6'h01;
		fire(8'hFF);
		rd(OFF_STATUS, rv);
		chk(rv, 32'h0000009D);
		// An event in the cycle of a status read survives that read
		@(posedge clock);
		fireReq <= 8'h10;
		@(posedge clock);
		fireReq <= 8'h00;
		regAddr <= OFF_STATUS;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rv = regRdata;
		chk(rv, 32'h00000000);
		rd(OFF_STATUS, rv);
		chk(rv, 32'h00000010);
		$display("test mode gating done");
		// Pin path is synchronised, so allow its full latency
		for (int k = 0; k < 64; k++) begin
			@(posedge clock);
			cfgReq <= 6'(k);
			repeat (6) @(posedge clock);
			rd(OFF_STATUS, rv);
			ln = k[0] ? k[3:2] : k[5:4];
			chk(rv, {13'h0, ln, k[1], 16'h0});
		end
		$display("test mirrors done");
		wr(OFF_IRQ_SET, 32'h000000FF);
		fire(8'h01);
		chk({31'h0, irqOut}, 32'h1);
		wr(OFF_IRQ_CLR, 32'h000000FF);
		chk({31'h0, irqOut}, 32'h0);
		wr(OFF_IRQ_SET, 32'h00000001);
		chk({31'h0, irqOut}, 32'h1);
		// Reset in mid-run must drop the mask and the interrupt
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk({31'h0, irqOut}, 32'h0);
		rd(OFF_IRQ_MASK, rv);
		chk(rv, 32'h00000000);
		$display("test reset done");
		summarize();
	end
endmodule
